// [bogr_pkg.sv]
package bogr_pkg;

  // Bus geometry: 32-bit data, registers sit one per aligned word
  localparam int BOGR_DW = 32;
  localparam int BOGR_AW = 12;
  localparam int BOGR_IW = 10;

  // Register indices as printed; byte address is four times the index
  localparam logic [9:0] IDX_SRC1_ADDR_BYTE0_RED = 10'h09D;
  localparam logic [9:0] IDX_SRC1_ADDR_BYTE1_GREEN = 10'h09E;
  localparam logic [9:0] IDX_SRC1_ADDR_BYTE2_BLUE = 10'h09F;
  localparam logic [9:0] IDX_SRC1_ADDR_BYTE3 = 10'h0A0;
  localparam logic [9:0] IDX_SRC1_WIDTH_LOW = 10'h0A1;
  localparam logic [9:0] IDX_SRC1_WIDTH_HIGH = 10'h0A2;
  localparam logic [9:0] IDX_SRC1_X_LOW = 10'h0A3;
  localparam logic [9:0] IDX_SRC1_X_HIGH = 10'h0A4;
  localparam logic [9:0] IDX_SRC1_Y_LOW = 10'h0A5;
  localparam logic [9:0] IDX_SRC1_Y_HIGH = 10'h0A6;
  localparam logic [9:0] IDX_DEST_ADDR_BYTE0 = 10'h0A7;
  localparam logic [9:0] IDX_DEST_ADDR_BYTE1 = 10'h0A8;
  localparam logic [9:0] IDX_DEST_ADDR_BYTE2 = 10'h0A9;
  localparam logic [9:0] IDX_DEST_ADDR_BYTE3 = 10'h0AA;
  localparam logic [9:0] IDX_DEST_WIDTH_LOW = 10'h0AB;
  localparam logic [9:0] IDX_DEST_WIDTH_HIGH = 10'h0AC;
  localparam logic [9:0] IDX_DEST_X_LOW = 10'h0AD;
  localparam logic [9:0] IDX_DEST_X_HIGH = 10'h0AE;
  localparam logic [9:0] IDX_DEST_Y_LOW = 10'h0AF;
  localparam logic [9:0] IDX_SRC1_DEPTH_CTRL = 10'h0F0;
  localparam logic [9:0] IDX_BANK_STATUS = 10'h0F1;

  // The byte bank is contiguous from the first to the last index
  localparam logic [9:0] BOGR_BANK_FIRST = IDX_SRC1_ADDR_BYTE0_RED;
  localparam logic [9:0] BOGR_BANK_LAST = IDX_DEST_Y_LOW;
  localparam int BOGR_NUM = 19;
  localparam int BOGR_SW = 5;

  // Writable bits of each bank byte, in bank order
  localparam logic [7:0] BOGR_WMASK [0:BOGR_NUM-1] = '{
    8'hFF, 8'hFF, 8'hFF, 8'hFF,   // Source 1 address or constant colour
    8'hFC, 8'h1F,                 // Source 1 width, low bits fixed
    8'hFF, 8'h1F, 8'hFF, 8'h1F,   // Source 1 X and Y
    8'hFC, 8'hFF, 8'hFF, 8'hFF,   // Destination address, low bits fixed
    8'hFC, 8'h1F,                 // Destination width, low bits fixed
    8'hFF, 8'h1F, 8'hFF           // Destination X and Y low
  };

  // Bank positions used by the output assembly
  localparam int POS_S1A0 = 0;
  localparam int POS_S1A1 = 1;
  localparam int POS_S1A2 = 2;
  localparam int POS_S1A3 = 3;
  localparam int POS_S1WL = 4;
  localparam int POS_S1WH = 5;
  localparam int POS_S1XL = 6;
  localparam int POS_S1XH = 7;
  localparam int POS_S1YL = 8;
  localparam int POS_S1YH = 9;
  localparam int POS_DA0 = 10;
  localparam int POS_DA1 = 11;
  localparam int POS_DA2 = 12;
  localparam int POS_DA3 = 13;
  localparam int POS_DWL = 14;
  localparam int POS_DWH = 15;
  localparam int POS_DXL = 16;
  localparam int POS_DXH = 17;
  localparam int POS_DYL = 18;

  // Field layouts and reset values
  localparam logic [7:0] BOGR_BYTE_RESET = 8'h00;
  localparam logic [2:0] BOGR_DEPTH_RESET = 3'h0;
  localparam logic [2:0] BOGR_DEPTH_CONST = 3'h3;
  localparam int BOGR_HI_W = 5;
  localparam int STAT_LIVE_CONST = 0;
  localparam int STAT_ACTIVE_CONST = 1;
  localparam int STAT_PENDING = 2;

endpackage

// [bogr_regs.sv]
// What this block does
// R1 - Source 1 address bytes two and three stored
// R2 - Constant mode: blue taken from address byte two
// R3 - Constant mode: top address byte ignored
// R4 - Source 1 width 13 bits, low two fixed zero
// R5 - Source 1 X stored as 13 bits
// R6 - Source 1 Y stored as 13 bits
// R7 - Destination address 32 bits, low two fixed zero
// R8 - Software keeps destination outside source regions
// R9 - Destination width 13 bits, low two fixed zero
// R10 - Destination X stored as 13 bits
// R11 - Destination Y low byte writable
// R12 - Depth code 011 selects constant colour mode
// R13 - Constant mode: red from lowest address byte
// R14 - Constant mode: green from address byte one
// R15 - Unused high bits ignore writes, read zero
// R16 - All reset zero; writes apply at next start
`timescale 1ns/1ps
module bogr_regs
  import bogr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [BOGR_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [BOGR_DW-1:0] wb_dat_i,
  output logic [BOGR_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic engineStart,
  output logic src1ConstMode,
  output logic [2:0] src1Depth,
  output logic [31:0] src1StartAddr,
  output logic [7:0] constColourRed,
  output logic [7:0] constColourGreen,
  output logic [7:0] constColourBlue,
  output logic [12:0] src1Width,
  output logic [12:0] src1X,
  output logic [12:0] src1Y,
  output logic [31:0] destStartAddr,
  output logic [12:0] destWidth,
  output logic [12:0] destX,
  output logic [7:0] destYLow
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset and blank words, built from the byte reset value so that
  // a change to the byte reset follows through every wide copy

  localparam logic [31:0] WORD_RESET = {4{BOGR_BYTE_RESET}};
  localparam logic [12:0] FIELD_RESET =
    {BOGR_BYTE_RESET[BOGR_HI_W-1:0], BOGR_BYTE_RESET};

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // True when the word index falls inside the byte bank
  function automatic logic bankHit(input logic [BOGR_IW-1:0] idx);
    bankHit = (idx >= BOGR_BANK_FIRST) && (idx <= BOGR_BANK_LAST);
  endfunction

  // Position inside the bank; only meaningful when bankHit is true
  function automatic logic [BOGR_SW-1:0] bankPos(
    input logic [BOGR_IW-1:0] idx);
    logic [BOGR_IW-1:0] diff;
    diff = idx - BOGR_BANK_FIRST;
    bankPos = diff[BOGR_SW-1:0];
  endfunction

  // Joins the live five bits of a high byte onto its low byte
  function automatic logic [12:0] join13(input logic [7:0] hi,
    input logic [7:0] lo);
    join13 = {hi[BOGR_HI_W-1:0], lo};
  endfunction

  // Joins four bank bytes, lowest address byte first
  function automatic logic [31:0] join32(input logic [7:0] b0,
    input logic [7:0] b1, input logic [7:0] b2, input logic [7:0] b3);
    join32 = {b3, b2, b1, b0};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus request qualification

  logic [BOGR_IW-1:0] wordIdx;
  logic reqLive;
  logic wrStb;
  logic ackReg;
  logic [BOGR_DW-1:0] rdataReg;

  // A request is served once; ack drops the cycle after it was given
  assign wordIdx = wb_adr_i[BOGR_AW-1:2];
  assign reqLive = wb_cyc_i && wb_stb_i && !ackReg;
  // Only lane 0 carries the byte registers
  assign wrStb = reqLive && wb_we_i && wb_sel_i[0];

  ////////////////////////////////////////////////////////////////////////////
  // Byte bank, one flop group per register

  logic [7:0] bankReg [0:BOGR_NUM-1];
  logic [BOGR_NUM-1:0] bankSel;

  // One-hot write select, decoded once for the whole bank; a write
  // with lane 0 off selects nothing, yet it is still acknowledged
  for (genvar i = 0; i < BOGR_NUM; i++) begin : gSel
    assign bankSel[i] = wrStb && bankHit(wordIdx) &&
                        bankPos(wordIdx) == BOGR_SW'(i);
  end

  // Masking on write keeps fixed and unused bits at zero for good
  for (genvar i = 0; i < BOGR_NUM; i++) begin : gBank
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        bankReg[i] <= BOGR_BYTE_RESET; // R16
      end else if (bankSel[i]) begin
        bankReg[i] <= wb_dat_i[7:0] & BOGR_WMASK[i]; // R1 R4 R7 R9 R15
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source 1 colour depth control

  logic [2:0] depthReg;
  logic liveConst;

  // Depth field is stored here so the constant mode can be decoded
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      depthReg <= BOGR_DEPTH_RESET; // R16
    end else if (wrStb && wordIdx == IDX_SRC1_DEPTH_CTRL) begin
      depthReg <= wb_dat_i[2:0];
    end
  end

  assign liveConst = (depthReg == BOGR_DEPTH_CONST); // R12

  ////////////////////////////////////////////////////////////////////////////
  // Pending flag: settings written but not yet used by a transfer

  logic pendingReg;
  logic bankWrite;

  assign bankWrite = wrStb && (bankHit(wordIdx) ||
                     wordIdx == IDX_SRC1_DEPTH_CTRL);

  // A write in the start cycle wins, since it misses that snapshot
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pendingReg <= 1'b0;
    end else if (bankWrite) begin
      pendingReg <= 1'b1;
    end else if (engineStart) begin
      pendingReg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Snapshot values assembled from the bank

  // Live values follow the bank at once; only the copies wait
  logic [31:0] src1AddrLive;
  logic [31:0] destAddrLive;
  logic [7:0] redLive;
  logic [7:0] greenLive;
  logic [7:0] blueLive;
  logic [12:0] src1WidthLive;
  logic [12:0] src1XLive;
  logic [12:0] src1YLive;
  logic [12:0] destWidthLive;
  logic [12:0] destXLive;

  // Constant mode blanks the whole address, top byte included, so a
  // stale top byte can never leak into an address the engine uses
  assign src1AddrLive = liveConst ? WORD_RESET : // R3
    join32(bankReg[POS_S1A0], bankReg[POS_S1A1],
           bankReg[POS_S1A2], bankReg[POS_S1A3]); // R1
  assign destAddrLive = join32(bankReg[POS_DA0], bankReg[POS_DA1],
                               bankReg[POS_DA2], bankReg[POS_DA3]); // R7

  // The same address bytes double as the constant colour; outside
  // constant mode the engine sees zero rather than an address byte
  assign redLive = liveConst ? bankReg[POS_S1A0] : BOGR_BYTE_RESET; // R13
  assign greenLive = liveConst ? bankReg[POS_S1A1] : BOGR_BYTE_RESET; // R14
  assign blueLive = liveConst ? bankReg[POS_S1A2] : BOGR_BYTE_RESET; // R2

  // Thirteen-bit fields: five live bits of the high byte over the low
  assign src1WidthLive = join13(bankReg[POS_S1WH], bankReg[POS_S1WL]); // R4
  assign src1XLive = join13(bankReg[POS_S1XH], bankReg[POS_S1XL]); // R5
  assign src1YLive = join13(bankReg[POS_S1YH], bankReg[POS_S1YL]); // R6
  assign destWidthLive = join13(bankReg[POS_DWH], bankReg[POS_DWL]); // R9
  assign destXLive = join13(bankReg[POS_DXH], bankReg[POS_DXL]); // R10

  ////////////////////////////////////////////////////////////////////////////
  // Engine-facing copies, loaded only when a transfer starts
  // Holding copies keeps a running transfer stable while software
  // reprograms the next one. A write in the start cycle misses the copy.

  // Constant mode flag
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src1ConstMode <= 1'b0;
    end else if (engineStart) begin
      src1ConstMode <= liveConst; // R12 R16
    end
  end

  // Depth field as the engine sees it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src1Depth <= BOGR_DEPTH_RESET;
    end else if (engineStart) begin
      src1Depth <= depthReg;
    end
  end

  // Source 1 start address
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src1StartAddr <= WORD_RESET;
    end else if (engineStart) begin
      src1StartAddr <= src1AddrLive; // R1 R3
    end
  end

  // Red component
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      constColourRed <= BOGR_BYTE_RESET;
    end else if (engineStart) begin
      constColourRed <= redLive; // R13
    end
  end

  // Green component
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      constColourGreen <= BOGR_BYTE_RESET;
    end else if (engineStart) begin
      constColourGreen <= greenLive; // R14
    end
  end

  // Blue component
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      constColourBlue <= BOGR_BYTE_RESET;
    end else if (engineStart) begin
      constColourBlue <= blueLive; // R2
    end
  end

  // Source 1 width; its low two bits were never writable
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src1Width <= FIELD_RESET;
    end else if (engineStart) begin
      src1Width <= src1WidthLive; // R4
    end
  end

  // Source 1 window X
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src1X <= FIELD_RESET;
    end else if (engineStart) begin
      src1X <= src1XLive; // R5
    end
  end

  // Source 1 window Y
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      src1Y <= FIELD_RESET;
    end else if (engineStart) begin
      src1Y <= src1YLive; // R6
    end
  end

  // Destination start address; overlap with the sources is left to
  // software, the bank does not check it
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      destStartAddr <= WORD_RESET;
    end else if (engineStart) begin
      destStartAddr <= destAddrLive; // R7
    end
  end

  // Destination width
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      destWidth <= FIELD_RESET;
    end else if (engineStart) begin
      destWidth <= destWidthLive; // R9
    end
  end

  // Destination window X
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      destX <= FIELD_RESET;
    end else if (engineStart) begin
      destX <= destXLive; // R10
    end
  end

  // Destination window Y low byte
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      destYLow <= BOGR_BYTE_RESET;
    end else if (engineStart) begin
      destYLow <= bankReg[POS_DYL]; // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data and acknowledge

  logic [BOGR_DW-1:0] rdataNext;
  logic [BOGR_DW-1:0] statWord;
  logic [BOGR_DW-1:0] depthWord;

  // Status bits: live mode, mode the engine holds, unapplied writes
  always_comb begin
    statWord = '0;
    statWord[STAT_LIVE_CONST] = liveConst;
    statWord[STAT_ACTIVE_CONST] = src1ConstMode;
    statWord[STAT_PENDING] = pendingReg;
  end

  // Depth field in the low bits, the rest reads zero
  always_comb begin
    depthWord = '0;
    depthWord[2:0] = depthReg;
  end

  // Unmapped words answer with zero so the bus never hangs
  always_comb begin
    rdataNext = '0;
    if (bankHit(wordIdx)) begin
      rdataNext[7:0] = bankReg[bankPos(wordIdx)]; // R15
    end else if (wordIdx == IDX_SRC1_DEPTH_CTRL) begin
      rdataNext = depthWord;
    end else if (wordIdx == IDX_BANK_STATUS) begin
      rdataNext = statWord;
    end
  end

  // Single-wait answer: ack one edge after the request is seen
  // Acking unmapped words too means a stray access never stalls
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ackReg <= 1'b0;
    end else begin
      ackReg <= reqLive;
    end
  end

  // Read data captured with the ack and held only for that cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdataReg <= '0;
    end else if (reqLive && !wb_we_i) begin
      rdataReg <= rdataNext;
    end else begin
      rdataReg <= '0;
    end
  end

  assign wb_ack_o = ackReg;
  assign wb_dat_o = rdataReg;

endmodule // bogr_regs

// [bogr_regs_monitor.sv]
`timescale 1ns/1ps
module bogr_regs_monitor
  import bogr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [BOGR_DW-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic engineStart,
  input wire logic src1ConstMode,
  input wire logic [2:0] src1Depth,
  input wire logic [31:0] src1StartAddr,
  input wire logic [7:0] constColourRed,
  input wire logic [7:0] constColourGreen,
  input wire logic [7:0] constColourBlue,
  input wire logic [12:0] src1Width,
  input wire logic [31:0] destStartAddr,
  input wire logic [12:0] destWidth,
  input wire logic [7:0] destYLow
);
  // One clock domain, so clocking and reset are given once
  default clocking monClk @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one ack, exactly one cycle after the request is taken
  ack_follows_a: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  read_byte_a: assert property
    (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data above byte");

  ////////////////////////////////////////////////////////////////////////////
  // Engine copies: mode, colour reuse and fixed low bits
  mode_match_a: assert property
    (src1ConstMode == (src1Depth == BOGR_DEPTH_CONST))
    else $error("const mode not tied to depth");
  const_addr_a: assert property
    (src1ConstMode |-> src1StartAddr == 32'h0)
    else $error("address live in const mode");
  colour_off_a: assert property
    (!src1ConstMode |->
      {constColourRed, constColourGreen, constColourBlue} == 24'h0)
    else $error("colour live outside const mode");
  low_bits_a: assert property
    (destStartAddr[1:0] == 2'b00 && destWidth[1:0] == 2'b00
      && src1Width[1:0] == 2'b00) else $error("fixed low bits set");
  // Copies must not drift between starts, or a transfer sees torn values
  hold_copy_a: assert property
    (!engineStart |=> $stable(destYLow) && $stable(src1StartAddr))
    else $error("copy changed without start");
endmodule // bogr_regs_monitor

bind bogr_regs bogr_regs_monitor mon_u (.ref_clk(ref_clk), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .engineStart(engineStart),
  .src1ConstMode(src1ConstMode), .src1Depth(src1Depth),
  .src1StartAddr(src1StartAddr), .constColourRed(constColourRed),
  .constColourGreen(constColourGreen), .constColourBlue(constColourBlue),
  .src1Width(src1Width), .destStartAddr(destStartAddr),
  .destWidth(destWidth), .destYLow(destYLow));

// [bogr_regs_tb.sv]
`timescale 1ns/1ps
module bogr_regs_tb;
  import bogr_pkg::*;
  logic ref_clk, rst_b, cyc, stb, we, ack, engineStart, constMode;
  logic [BOGR_AW-1:0] adr;
  logic [3:0] sel;
  logic [31:0] datI, datO, q, s1Addr, dAddr;
  logic [2:0] depth;
  logic [7:0] red, green, blue, dYLow, p;
  logic [12:0] s1W, s1X, s1Y, dW, dX;
  logic [7:0] s [0:18];
  // Writable bits per bank byte, kept apart from the design's own table
  localparam logic [7:0] MASK [0:18] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFC,
    8'h1F, 8'hFF, 8'h1F, 8'hFF, 8'h1F, 8'hFC, 8'hFF, 8'hFF, 8'hFF, 8'hFC,
    8'h1F, 8'hFF, 8'h1F, 8'hFF};
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  bogr_regs dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack),
    .engineStart(engineStart), .src1ConstMode(constMode),
    .src1Depth(depth), .src1StartAddr(s1Addr), .constColourRed(red),
    .constColourGreen(green), .constColourBlue(blue), .src1Width(s1W),
    .src1X(s1X), .src1Y(s1Y), .destStartAddr(dAddr), .destWidth(dW),
    .destX(dX), .destYLow(dYLow));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and a hang guard well above the roughly 330 cycles needed
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // Classic cycle: request held until ack is sampled, then one idle cycle
  task automatic bus(input logic [9:0] i, input logic w, input logic [7:0] d,
    input logic [3:0] m);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    sel <= m;
    datI <= {24'h0, d};
    @(posedge ref_clk);
    while (ack !== 1'b1) @(posedge ref_clk);
    q = datO;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    bus(i, 1'b0, 8'h00, 4'hF);
    chk(q, {24'h0, e});
  endtask
  task automatic go();
    engineStart <= 1'b1;
    @(posedge ref_clk);
    engineStart <= 1'b0;
    @(posedge ref_clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    {cyc, stb, we, engineStart, adr, sel, datI} = '0;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 19; i++) rd(BOGR_BANK_FIRST + 10'(i), 8'h00);
    // All ones first exposes fixed and unused bits
    for (int i = 0; i < 19; i++) begin
      bus(BOGR_BANK_FIRST + 10'(i), 1'b1, 8'hFF, 4'hF);
      rd(BOGR_BANK_FIRST + 10'(i), MASK[i]);
    end
    for (int i = 0; i < 19; i++) begin
      p = 8'h5A + 8'(i * 29);
      s[i] = p & MASK[i];
      bus(BOGR_BANK_FIRST + 10'(i), 1'b1, p, 4'hF);
    end
    chk(32'(dYLow), 32'h0);
    // Bank written but no start yet: only the pending bit is up
    p = 8'h00;
    p[STAT_PENDING] = 1'b1;
    rd(IDX_BANK_STATUS, p);
    bus(IDX_DEST_Y_LOW, 1'b1, 8'h00, 4'hE);
    rd(IDX_DEST_Y_LOW, s[18]);
    bus(10'h0B0, 1'b1, 8'hFF, 4'hF);
    rd(10'h0B0, 8'h00);
    // Every depth code; only 011 turns the address into a colour
    for (int d = 0; d < 8; d++) begin
      bus(IDX_SRC1_DEPTH_CTRL, 1'b1, 8'(d), 4'hF);
      go();
      chk(32'(constMode), 32'(d == 3));
      chk(32'(depth), 32'(d));
      chk(s1Addr, d == 3 ? 32'h0 : {s[3], s[2], s[1], s[0]});
      chk({8'h0, red, green, blue},
        d == 3 ? {8'h0, s[0], s[1], s[2]} : 32'h0);
      rd(IDX_SRC1_DEPTH_CTRL, 8'(d));
      p = 8'h00;
      p[STAT_LIVE_CONST] = (d == 3);
      p[STAT_ACTIVE_CONST] = (d == 3);
      rd(IDX_BANK_STATUS, p);
    end
    chk(32'(s1W), 32'({s[5][4:0], s[4]}));
    chk(32'(s1X), 32'({s[7][4:0], s[6]}));
    chk(32'(s1Y), 32'({s[9][4:0], s[8]}));
    chk(dAddr, {s[13], s[12], s[11], s[10]});
    chk(32'(dW), 32'({s[15][4:0], s[14]}));
    chk(32'(dX), 32'({s[17][4:0], s[16]}));
    chk(32'(dYLow), 32'(s[18]));
    results();
  end
endmodule // bogr_regs_tb
